// ===== aux_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module aux_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q];

    always_comb begin
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop  ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule : aux_fifo

// ===== aux_handshake_timing.sv
// Auxiliary DMA port handshake timing engine with its timing registers
// Operation
// - Upper nibble selects acknowledge assert moment
// - Codes 0-11 wait code+1 link cycles
// - Code 12 fires on request asserted
// - Code 13 needs request and ready released
// - Code 14 fires on FIFO capture
// - Code 15 fires on ready pin asserted
// - Lower nibble selects ready indication, same codes
// - Source and destination have separate selectors
// - Source release 1-12 cycles after ready
// - Release 12 rdy pin, 14 FIFO, 15 ready
`timescale 1ns/1ps
module aux_handshake_timing
    import aux_timing_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int DEPTH  = aux_timing_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                              SYS_CLK,
    input  wire logic                              SRST,
    // Register port
    input  wire logic [aux_timing_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic                              REG_WR,
    input  wire logic [aux_timing_pkg::REG_W-1:0]  REG_WDATA,
    output logic      [aux_timing_pkg::REG_W-1:0]  REG_RDATA,
    // DMA controller side
    input  wire logic                              CYCLE_START,
    input  wire logic                              CYCLE_WRITE,
    output logic                                   CYCLE_BUSY,
    output logic                                   READY_PULSE,
    // Auxiliary peripheral pins
    input  wire logic                              SIDE_REQUEST_IN,
    input  wire logic                              SIDE_READY_IN,
    output logic                                   SIDE_ACKNOWLEDGE_OUT,
    input  wire logic [DATA_W-1:0]                 SIDE_DATA_IN,
    output logic      [DATA_W-1:0]                 SIDE_DATA_OUT,
    // Read data stream toward the DMA controller
    output logic                                   RD_VALID,
    input  wire logic                              RD_READY,
    output logic      [DATA_W-1:0]                 RD_DATA,
    // Write data stream from the DMA controller
    input  wire logic                              WR_VALID,
    output logic                                   WR_READY,
    input  wire logic [DATA_W-1:0]                 WR_DATA
);
    import aux_timing_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ASSERT, ST_READY, ST_RELEASE} phase_e;

    logic [7:0]  src_attr_q, src_attr_d, dst_attr_q, dst_attr_d;
    logic [7:0]  src_ar_q, src_ar_d, dst_ar_q, dst_ar_d, src_rel_q, src_rel_d;
    logic [15:0] ph_q, ph_d;
    logic        tick;
    phase_e      st_q, st_d;
    logic        wr_q, wr_d, ack_q, ack_d;
    logic        ack_done_q, ack_done_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [3:0]  ack_sel, rdy_sel, rel_sel;
    logic        captured, cap_seen, ack_hit, rdy_hit, rel_hit, rdy_fire;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic        fifo_in_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    // One selector code resolved against the current events and cycle count
    function automatic logic sel_hit(input logic [3:0] sel, input logic [3:0] cnt,
                                     input logic tk, input logic req, input logic rdy,
                                     input logic cap);
        case (sel)
            SEL_REQ:      sel_hit = req;
            SEL_REQ_NRDY: sel_hit = req && !rdy;
            SEL_FIFO:     sel_hit = cap;
            SEL_RDY:      sel_hit = rdy;
            default:      sel_hit = tk && (cnt == sel);
        endcase
    endfunction : sel_hit

    // Register file; all fields clear on reset
    always_comb begin
        src_attr_d = src_attr_q;
        dst_attr_d = dst_attr_q;
        src_ar_d   = src_ar_q;
        dst_ar_d   = dst_ar_q;
        src_rel_d  = src_rel_q;
        if (REG_WR) begin
            case (REG_ADDR)
                IDX_SRC_ATTR: src_attr_d = REG_WDATA;
                IDX_DST_ATTR: dst_attr_d = REG_WDATA;
                IDX_SRC_AR:   src_ar_d   = REG_WDATA;
                IDX_DST_AR:   dst_ar_d   = REG_WDATA;
                IDX_SRC_REL:  src_rel_d  = REG_WDATA;
                default:      src_attr_d = src_attr_q;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            src_attr_q <= RESET_VALUE;
            dst_attr_q <= RESET_VALUE;
            src_ar_q   <= RESET_VALUE;
            dst_ar_q   <= RESET_VALUE;
            src_rel_q  <= RESET_VALUE;
        end else begin
            src_attr_q <= src_attr_d;
            dst_attr_q <= dst_attr_d;
            src_ar_q   <= src_ar_d;
            dst_ar_q   <= dst_ar_d;
            src_rel_q  <= src_rel_d;
        end
    end

    always_comb begin
        case (REG_ADDR)
            IDX_SRC_ATTR: REG_RDATA = src_attr_q;
            IDX_DST_ATTR: REG_RDATA = dst_attr_q;
            IDX_SRC_AR:   REG_RDATA = src_ar_q;
            IDX_DST_AR:   REG_RDATA = dst_ar_q;
            IDX_SRC_REL:  REG_RDATA = src_rel_q;
            default:      REG_RDATA = {6'h00, ack_q, CYCLE_BUSY};
        endcase
    end

    // Fractional divider: 32 MHz link ticks out of the 40 MHz clock, four in five cycles
    always_comb begin
        if (ph_q + PHASE_STEP >= PHASE_MOD) begin
            ph_d = 16'(ph_q + PHASE_STEP - PHASE_MOD);
            tick = 1'b1;
        end else begin
            ph_d = 16'(ph_q + PHASE_STEP);
            tick = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ph_q <= 16'h0000;
        end else begin
            ph_q <= ph_d;
        end
    end

    // Reads use the source selectors, writes the destination ones
    assign ack_sel = wr_q ? dst_ar_q[ACK_SEL_HI:ACK_SEL_LO]
                          : src_ar_q[ACK_SEL_HI:ACK_SEL_LO];
    assign rdy_sel = wr_q ? dst_ar_q[RDY_SEL_HI:RDY_SEL_LO]
                          : src_ar_q[RDY_SEL_HI:RDY_SEL_LO];
    assign rel_sel = src_rel_q[ACK_SEL_HI:ACK_SEL_LO];

    // Capture: a read word enters the FIFO, or a written word leaves it onto the pins
    assign captured = wr_q ? (st_q != ST_IDLE && !ack_done_q && fifo_out_valid)
                           : (st_q != ST_IDLE && !ack_done_q && SIDE_READY_IN
                              && fifo_in_ready);
    assign ack_hit  = sel_hit(ack_sel, cnt_q, tick, SIDE_REQUEST_IN, SIDE_READY_IN,
                              captured);
    // A word captured during an earlier phase still counts, else code 14 would hang
    assign cap_seen = captured || ack_done_q;
    assign rdy_hit  = sel_hit(rdy_sel, cnt_q, tick, SIDE_REQUEST_IN, SIDE_READY_IN,
                              cap_seen);

    // Release codes 12, 13 and 15 differ from the assert table; 13 is treated like 12
    always_comb begin
        case (rel_sel)
            REL_RDY_PIN, SEL_REQ_NRDY: rel_hit = SIDE_READY_IN;
            SEL_FIFO:                  rel_hit = cap_seen;
            REL_VALID_RDY:             rel_hit = 1'b1;
            default:                   rel_hit = tick && (cnt_q == rel_sel);
        endcase
    end

    always_comb begin
        st_d        = st_q;
        wr_d        = wr_q;
        ack_d       = ack_q;
        cnt_d       = cnt_q;
        ack_done_d  = ack_done_q;
        rdy_fire    = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (CYCLE_START) begin
                    st_d       = ST_ASSERT;
                    wr_d       = CYCLE_WRITE;
                    cnt_d      = 4'h0;
                    ack_done_d = 1'b0;
                end
            end
            ST_ASSERT: begin
                if (ack_hit) begin
                    ack_d = 1'b1;
                    st_d  = ST_READY;
                    cnt_d = 4'h0;
                end else if (tick && cnt_q != SEL_LAST_FIX) begin
                    cnt_d = cnt_q + 4'h1;
                end
                if (captured) begin
                    ack_done_d = 1'b1;
                end
            end
            ST_READY: begin
                if (rdy_hit) begin
                    rdy_fire = 1'b1;
                    st_d     = ST_RELEASE;
                    cnt_d    = 4'h0;
                end else if (tick && cnt_q != SEL_LAST_FIX) begin
                    cnt_d = cnt_q + 4'h1;
                end
                if (captured) begin
                    ack_done_d = 1'b1;
                end
            end
            ST_RELEASE: begin
                // Destination release table is outside this block: release on ready
                if (wr_q || rel_hit) begin
                    ack_d = 1'b0;
                    st_d  = ST_IDLE;
                end else if (tick && cnt_q != SEL_LAST_FIX) begin
                    cnt_d = cnt_q + 4'h1;
                end
                if (captured) begin
                    ack_done_d = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            st_q        <= ST_IDLE;
            wr_q        <= 1'b0;
            ack_q       <= 1'b0;
            cnt_q       <= 4'h0;
            ack_done_q  <= 1'b0;
        end else begin
            st_q        <= st_d;
            wr_q        <= wr_d;
            ack_q       <= ack_d;
            cnt_q       <= cnt_d;
            ack_done_q  <= ack_done_d;
        end
    end

    assign CYCLE_BUSY           = (st_q != ST_IDLE);
    assign READY_PULSE          = rdy_fire;
    assign SIDE_ACKNOWLEDGE_OUT = ack_q;

    // Write data is held on the pins from the word last taken out of the FIFO
    always_comb begin
        dout_d = (wr_q && captured) ? fifo_out_data : dout_q;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            dout_q <= '0;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign SIDE_DATA_OUT = dout_q;

    // One FIFO shared by both directions; the cycle direction picks its ends
    logic              f_in_valid, f_out_ready;
    logic [DATA_W-1:0] f_in_data;
    assign f_in_valid  = wr_q ? (WR_VALID && !CYCLE_BUSY) || (WR_VALID && wr_q)
                              : captured;
    assign f_in_data   = wr_q ? WR_DATA : SIDE_DATA_IN;
    assign f_out_ready = wr_q ? captured : RD_READY;
    assign WR_READY    = wr_q && fifo_in_ready;
    assign RD_VALID    = !wr_q && fifo_out_valid;
    assign RD_DATA     = fifo_out_data;

    aux_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .srst      (SRST),
        .in_valid  (f_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (f_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (f_out_ready),
        .out_data  (fifo_out_data)
    );

    a_ack_fixed_delay: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_ASSERT && ack_sel <= SEL_LAST_FIX && ack_hit) |=> SIDE_ACKNOWLEDGE_OUT)
        else $error("acknowledge not asserted after fixed delay");
    a_ack_on_request: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_ASSERT && ack_sel == SEL_REQ && SIDE_REQUEST_IN) |=> SIDE_ACKNOWLEDGE_OUT)
        else $error("acknowledge missed request");
    a_ack_req_nrdy: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_ASSERT && ack_sel == SEL_REQ_NRDY && SIDE_READY_IN) |=> !$rose(ack_q))
        else $error("acknowledge while ready still held");
    a_ack_on_ready: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_ASSERT && ack_sel == SEL_RDY && SIDE_READY_IN) |=> SIDE_ACKNOWLEDGE_OUT)
        else $error("acknowledge missed ready pin");
    a_ack_on_capture: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_ASSERT && ack_sel == SEL_FIFO && captured) |=> SIDE_ACKNOWLEDGE_OUT)
        else $error("acknowledge missed capture");
    a_ready_after_ack: assert property (@(posedge SYS_CLK) disable iff (SRST)
        READY_PULSE |-> SIDE_ACKNOWLEDGE_OUT && st_q == ST_READY)
        else $error("ready indication outside ready phase");
    a_release_bound: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_RELEASE && !wr_q && rel_sel <= SEL_LAST_FIX) |-> ##[0:20] !ack_q)
        else $error("acknowledge release too late");
    a_reset_clear: assert property (@(posedge SYS_CLK)
        SRST |=> src_ar_q == 8'h00 && dst_ar_q == 8'h00 && src_rel_q == 8'h00)
        else $error("timing fields not cleared");

    // Ticks seen in the assert phase, counted apart from cnt_q so the check does not reuse it
    logic [4:0] ast_ticks_q, ast_ticks_d;

    always_comb begin
        ast_ticks_d = ast_ticks_q;
        if (st_q != ST_ASSERT) begin
            ast_ticks_d = 5'h00;
        end else if (tick && ast_ticks_q != 5'h1F) begin
            ast_ticks_d = ast_ticks_q + 5'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ast_ticks_q <= 5'h00;
        end else begin
            ast_ticks_q <= ast_ticks_d;
        end
    end

    a_ack_tick_count: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_ASSERT && ack_sel <= SEL_LAST_FIX && tick)
        |=> SIDE_ACKNOWLEDGE_OUT == ({1'b0, $past(ack_sel)} == $past(ast_ticks_q)))
        else $error("acknowledge tick count differs from code");
    a_ready_on_capture: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_READY && rdy_sel == SEL_FIFO && ack_done_q) |-> READY_PULSE)
        else $error("ready missed earlier capture");
    a_release_on_pin: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_RELEASE && !wr_q && rel_sel == REL_RDY_PIN && SIDE_READY_IN)
        |=> !SIDE_ACKNOWLEDGE_OUT)
        else $error("acknowledge held past ready pin");
    a_release_on_cap: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (st_q == ST_RELEASE && !wr_q && rel_sel == SEL_FIFO && cap_seen)
        |=> !SIDE_ACKNOWLEDGE_OUT)
        else $error("acknowledge held past capture");
    a_write_release: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (READY_PULSE && wr_q) |-> ##2 !SIDE_ACKNOWLEDGE_OUT)
        else $error("write acknowledge not released after ready");
    a_start_dir: assert property (@(posedge SYS_CLK) disable iff (SRST)
        (CYCLE_START && !CYCLE_BUSY) |=> CYCLE_BUSY && wr_q == $past(CYCLE_WRITE))
        else $error("cycle start or direction not taken");
endmodule : aux_handshake_timing

// ===== aux_handshake_timing_tb.sv
// Self-checking bench for the auxiliary handshake timing engine
`timescale 1ns/1ps
module aux_handshake_timing_tb;
    import aux_timing_pkg::*;
    logic       clk = 1'b0, srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic       start = 1'b0, wr_cyc = 1'b0, busy, rdy_pulse;
    logic       req, rdy, ack;
    logic [7:0] sdata_in, sdata_out, rd_data;
    logic       rd_valid, rd_ready = 1'b1, wr_valid = 1'b0, wr_ready;
    logic [7:0] wr_data = 8'h00;
    logic       arm = 1'b0;
    logic [7:0] req_at = 8'h01, rdy_at = 8'h02, rdy_len = 8'h03, value = 8'h00;
    int         err_total = 0, n_compared = 0, cyc = 0;
    int         t_ack, t_rdy, t_rel;

    always #12.5 clk = ~clk;

    aux_handshake_timing #(.DATA_W(8), .DEPTH(FIFO_DEPTH)) i_dut (
        .SYS_CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .CYCLE_START(start),
        .CYCLE_WRITE(wr_cyc), .CYCLE_BUSY(busy), .READY_PULSE(rdy_pulse),
        .SIDE_REQUEST_IN(req), .SIDE_READY_IN(rdy), .SIDE_ACKNOWLEDGE_OUT(ack),
        .SIDE_DATA_IN(sdata_in), .SIDE_DATA_OUT(sdata_out), .RD_VALID(rd_valid),
        .RD_READY(rd_ready), .RD_DATA(rd_data), .WR_VALID(wr_valid),
        .WR_READY(wr_ready), .WR_DATA(wr_data));

    aux_peripheral_model i_peer (
        .clk(clk), .srst(srst), .arm(arm), .req_at(req_at), .rdy_at(rdy_at),
        .rdy_len(rdy_len), .value(value), .ack(ack), .req(req), .rdy(rdy),
        .data(sdata_in));

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Timings are measured in whole cycles, so a window allows for the link divider
    function automatic logic [7:0] win(input int t, input int lo, input int hi);
        return (t >= lo && t <= hi) ? 8'h01 : 8'h00;
    endfunction : win

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        #1;
        chk("register", reg_rdata, exp);
    endtask : reg_check

    // One auxiliary cycle; times count edges after the edge that takes the start
    task automatic run(input logic w, input logic [7:0] ra, input logic [7:0] ya,
                       input logic [7:0] yl, input logic [7:0] v);
        logic took;
        took  = 1'b0;
        t_ack = -1;
        t_rdy = -1;
        t_rel = -1;
        @(posedge clk);
        start   <= 1'b1;
        wr_cyc  <= w;
        arm     <= 1'b1;
        req_at  <= ra;
        rdy_at  <= ya;
        rdy_len <= yl;
        value   <= v;
        @(posedge clk);
        start <= 1'b0;
        arm   <= 1'b0;
        // A word offered before the loop is taken at its first edge
        #1;
        took = wr_valid && wr_ready;
        for (int k = 1; k < 120; k++) begin
            @(posedge clk);
            if (took) wr_valid <= 1'b0;
            #1;
            took = wr_valid && wr_ready;
            if (ack === 1'b1 && t_ack < 0) t_ack = k;
            if (rdy_pulse === 1'b1 && t_rdy < 0) t_rdy = k;
            if (ack === 1'b0 && t_ack >= 0 && t_rel < 0) t_rel = k;
            if (busy === 1'b0 && t_rel >= 0) break;
        end
    endtask : run

    task automatic t_regs;
        for (int i = 0; i < 5; i++) reg_check(3'(i), RESET_VALUE);
        run(1'b0, 8'd1, 8'd2, 8'd3, 8'h3C);
        chk("reset ack", win(t_ack, 0, 4), 8'h01);
        chk("reset release", win(t_rel - t_rdy, 1, 5), 8'h01);
        for (int i = 0; i < 5; i++) reg_write(3'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < 5; i++) reg_check(3'(i), 8'hA0 + 8'(i));
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) reg_check(3'(i), RESET_VALUE);
        reg_write(3'h5, 8'hFF);
        reg_check(3'h5, 8'h00);
        $display("test registers done");
    endtask : t_regs

    task automatic t_fixed;
        int b;
        reg_write(IDX_SRC_REL, 8'h00);
        for (int n = 0; n < 12; n += 5) begin
            b = (n + 1) * 5 / 4;
            reg_write(IDX_SRC_AR, {4'(n), 4'h0});
            run(1'b0, 8'd1, 8'd2, 8'd3, 8'h3C);
            chk("ack delay", win(t_ack, b - 1, b + 3), 8'h01);
            reg_write(IDX_SRC_AR, {4'h0, 4'(n)});
            run(1'b0, 8'd1, 8'd2, 8'd3, 8'h3C);
            chk("ready delay", win(t_rdy, b, b + 7), 8'h01);
        end
        $display("test fixed delays done");
    endtask : t_fixed

    task automatic t_events;
        logic [3:0] ev [4] = '{SEL_REQ, SEL_REQ_NRDY, SEL_FIFO, SEL_RDY};
        int ra [4] = '{10, 2, 2, 2};
        int ya [4] = '{14, 1, 8, 10};
        int yl [4] = '{3, 11, 3, 3};
        int lo [4] = '{9, 11, 7, 9};
        for (int i = 0; i < 4; i++) begin
            reg_write(IDX_SRC_AR, {ev[i], ev[i]});
            run(1'b0, 8'(ra[i]), 8'(ya[i]), 8'(yl[i]), 8'h5C);
            chk("event ack", win(t_ack, lo[i], lo[i] + 4), 8'h01);
            chk("event ready", win(t_rdy, lo[i], lo[i] + 5), 8'h01);
        end
        $display("test event selectors done");
    endtask : t_events

    task automatic t_release;
        reg_write(IDX_SRC_AR, 8'h00);
        reg_write(IDX_SRC_REL, {SEL_LAST_FIX, 4'h0});
        run(1'b0, 8'd1, 8'd2, 8'd3, 8'h21);
        chk("release fixed", win(t_rel - t_rdy, 14, 18), 8'h01);
        reg_write(IDX_SRC_REL, {REL_RDY_PIN, 4'h0});
        run(1'b0, 8'd1, 8'd20, 8'd4, 8'h22);
        chk("release on pin", win(t_rel, 19, 23), 8'h01);
        reg_write(IDX_SRC_REL, {REL_VALID_RDY, 4'h0});
        run(1'b0, 8'd1, 8'd2, 8'd3, 8'h23);
        chk("release on ready", win(t_rel - t_rdy, 0, 3), 8'h01);
        reg_write(IDX_SRC_REL, {SEL_FIFO, 4'h0});
        run(1'b0, 8'd1, 8'd2, 8'd3, 8'h24);
        chk("release on capture", win(t_rel - t_rdy, 0, 3), 8'h01);
        reg_write(IDX_SRC_REL, 8'h00);
        $display("test release done");
    endtask : t_release

    task automatic t_dest;
        reg_write(IDX_SRC_AR, 8'hBB);
        reg_write(IDX_DST_AR, 8'h00);
        wr_data  <= 8'h5A;
        wr_valid <= 1'b1;
        run(1'b1, 8'd1, 8'd2, 8'd3, 8'h00);
        chk("write ack", win(t_ack, 0, 4), 8'h01);
        chk("write data", sdata_out, 8'h5A);
        run(1'b0, 8'd1, 8'd2, 8'd3, 8'h44);
        chk("read ack", win(t_ack, 14, 18), 8'h01);
        reg_write(IDX_SRC_AR, 8'h00);
        $display("test direction done");
    endtask : t_dest

    task automatic t_fifo;
        @(posedge clk);
        rd_ready <= 1'b0;
        for (int i = 1; i <= 8; i++) run(1'b0, 8'd1, 8'd2, 8'd3, 8'h11 * 8'(i));
        for (int i = 1; i <= 8; i++) begin
            chk("fifo valid", {7'h00, rd_valid}, 8'h01);
            chk("fifo data", rd_data, 8'h11 * 8'(i));
            @(posedge clk);
            rd_ready <= 1'b1;
            @(posedge clk);
            rd_ready <= 1'b0;
            @(posedge clk);
            #1;
        end
        chk("fifo empty", {7'h00, rd_valid}, 8'h00);
        $display("test buffer done");
    endtask : t_fifo

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_fixed();
        t_events();
        t_release();
        t_dest();
        t_fifo();
        summarize();
    end
endmodule : aux_handshake_timing_tb

// ===== aux_peripheral_model.sv
// Behavioural auxiliary peripheral: request, ready and read data pins
`timescale 1ns/1ps
module aux_peripheral_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Scenario control from the bench
    input  wire logic       arm,
    input  wire logic [7:0] req_at,
    input  wire logic [7:0] rdy_at,
    input  wire logic [7:0] rdy_len,
    input  wire logic [7:0] value,
    // Peripheral pins
    input  wire logic       ack,
    output logic            req,
    output logic            rdy,
    output logic      [7:0] data
);
    logic [7:0] cnt_q;
    logic       ack_q;
    logic       done_q;

    always_ff @(posedge clk) begin
        ack_q <= ack;
        if (srst) begin
            cnt_q  <= 8'h00;
            done_q <= 1'b1;
        end else if (arm) begin
            cnt_q  <= 8'h01;
            done_q <= 1'b0;
        end else begin
            if (cnt_q != 8'h00 && cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
            if (ack_q && !ack) done_q <= 1'b1;
        end
    end

    // Request is held until the acknowledge is released
    assign req  = !done_q && (cnt_q >= req_at);
    // Ready is a timed window, so it can be gone before the request counts
    assign rdy  = !done_q && (cnt_q >= rdy_at) && (cnt_q < rdy_at + rdy_len);
    // Released bus shows the inverse so a stale byte never matches
    assign data = rdy ? value : ~value;
endmodule : aux_peripheral_model

// ===== aux_timing_pkg.sv
// Package with register layout and selector codes for the auxiliary handshake timer
package aux_timing_pkg;
    localparam int          REG_W         = 8;
    localparam int          SEL_W         = 4;
    localparam int          ADDR_W        = 3;
    // Register index on the byte-wide register port
    localparam logic [2:0]  IDX_SRC_ATTR  = 3'h0;
    localparam logic [2:0]  IDX_DST_ATTR  = 3'h1;
    localparam logic [2:0]  IDX_SRC_AR    = 3'h2;
    localparam logic [2:0]  IDX_DST_AR    = 3'h3;
    localparam logic [2:0]  IDX_SRC_REL   = 3'h4;
    localparam logic [7:0]  RESET_VALUE   = 8'h00;
    // Field positions inside a timing register
    localparam int          ACK_SEL_HI    = 7;
    localparam int          ACK_SEL_LO    = 4;
    localparam int          RDY_SEL_HI    = 3;
    localparam int          RDY_SEL_LO    = 0;
    // Selector codes
    localparam logic [3:0]  SEL_LAST_FIX  = 4'hB;
    localparam logic [3:0]  SEL_REQ       = 4'hC;
    localparam logic [3:0]  SEL_REQ_NRDY  = 4'hD;
    localparam logic [3:0]  SEL_FIFO      = 4'hE;
    localparam logic [3:0]  SEL_RDY       = 4'hF;
    localparam logic [3:0]  REL_RDY_PIN   = 4'hC;
    localparam logic [3:0]  REL_VALID_RDY = 4'hF;
    // Link clock: 32 MHz derived from the 40 MHz system clock
    localparam int          SYS_KHZ       = 40000;
    localparam int          LINK_KHZ      = 32000;
    localparam logic [15:0] PHASE_STEP    = 16'(LINK_KHZ);
    localparam logic [15:0] PHASE_MOD     = 16'(SYS_KHZ);
    localparam int          FIFO_DEPTH    = 8;
endpackage : aux_timing_pkg
